// *** design/sbg_pkg.sv ***
// package: constants and types for the system bus glue controller
package sbg_pkg;
    // ---------------------------------------------------------------
    // address map (word address a[20:1])
    // ---------------------------------------------------------------
    localparam logic [19:0] ROM_BASE_DEF   = 20'hc0000; // 0.5 MB rom area
    localparam logic [19:0] ROM_MASK       = 20'hc0000;
    localparam logic [19:0] IO_BASE_DEF    = 20'hb0000; // external i/o area
    localparam logic [19:0] IO_MASK        = 20'hf0000;
    localparam logic [19:0] DRAM_LIMIT     = 20'hc0000; // 1.5 MB dram below
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int          CLK_MHZ        = 100;
    localparam int          WDOG_US        = 64;
    localparam int          WDOG_CYC       = WDOG_US * CLK_MHZ;
    localparam int          RST_US         = 100;
    localparam int          RST_CYC        = RST_US * CLK_MHZ;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SBG_IDLE  = 2'b00,
        SBG_ACK   = 2'b01,
        SBG_BERR  = 2'b10,
        SBG_WAIT  = 2'b11
    } sbg_bus_state_t;
endpackage

// *** design/sbg_cnt_if.sv ***
// interface: timer control between glue top and counter
`timescale 1ns/1ns
`default_nettype none
interface sbg_cnt_if;
    logic        restart;
    logic        run;
    logic [15:0] limit;
    logic        expired;
    modport owner (output restart, output run, output limit, input expired);
    modport timer (input restart, input run, input limit, output expired);
endinterface
`default_nettype wire

// *** design/sbg_timer.sv ***
// module: restartable down-counting timer with expiry flag
`timescale 1ns/1ns
`default_nettype none
module sbg_timer
    import sbg_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    sbg_cnt_if.timer   ctl
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             exp_q;
    logic             exp_d;

    always_comb begin
        cnt_d = cnt_q;
        exp_d = exp_q;
        if (ctl.restart) begin
            cnt_d = ctl.limit;
            exp_d = 1'b0;
        end else if (ctl.run && !exp_q) begin
            if (cnt_q <= 16'h0001) begin
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign ctl.expired = exp_q;
endmodule
`default_nettype wire

// *** design/sbg_glue.sv ***
// module: system bus glue controller top
//
// Behaviour
// R1 - cpu holds address while strobes low
// R2 - write data stable; drive only reads
// R3 - upper strobe d0-7, lower d8-15
// R4 - direction low means write
// R5 - ignore accesses without chip select
// R6 - open-drain acknowledge when cycle proceeds
// R7 - reset output low during sequence
// R8 - halt output low during sequence
// R9 - low reset input starts sequence
// R10 - bus error on strobe at timeout
// R11 - rom select on strobed rom reads
// R12 - io select on strobed io accesses
// R13 - open-drain interrupt request output
// R14 - crystal divided by two output
// R15 - crystal divided by four output
// R16 - map 1.5 MB dram, 0.5 MB rom
// R17 - timeout and bases are parameters
// R18 - watchdog restarts per cycle, stops idle
`timescale 1ns/1ns
`default_nettype none
module sbg_glue
    import sbg_pkg::*;
#(
    parameter int          WDOG_CYCLES = WDOG_CYC,
    parameter int          RST_CYCLES  = RST_CYC,
    parameter logic [19:0] ROM_BASE    = ROM_BASE_DEF,
    parameter logic [19:0] IO_BASE     = IO_BASE_DEF
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [20:1] addr,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic      [15:0] data_oe,
    input  wire logic        upper_byte_strobe_n,
    input  wire logic        lower_byte_strobe_n,
    input  wire logic        read_not_write,
    input  wire logic        device_select_n,
    input  wire logic        reset_in_n,
    input  wire logic        irq_req,
    input  wire logic [15:0] rd_data,
    output logic      [15:0] wr_data,
    output logic      [1:0]  wr_lanes,
    output logic             wr_strobe,
    output logic             dram_select,
    output logic             transfer_ack_n,
    output logic             transfer_ack_oe,
    output logic             reset_out_n,
    output logic             reset_out_oe,
    output logic             halt_out_n,
    output logic             halt_out_oe,
    output logic             bus_error_n,
    output logic             bus_error_oe,
    output logic             rom_select_n,
    output logic             io_select_n,
    output logic             irq_out_n,
    output logic             irq_out_oe,
    output logic             crystal_half_clock,
    output logic             crystal_quarter_clock
);
    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    logic       strobe;
    logic       sel;
    logic       in_rom;
    logic       in_io;
    logic       in_dram;
    logic [1:0] lanes;

    // byte lanes: upper strobe on d0-7, lower on d8-15
    assign lanes   = {~lower_byte_strobe_n, ~upper_byte_strobe_n}; // R3
    assign strobe  = |lanes;
    assign sel     = strobe && !device_select_n; // R5 R1
    assign in_rom  = (addr & ROM_MASK) == ROM_BASE; // R16 R17
    assign in_io   = (addr & IO_MASK) == IO_BASE; // R17
    assign in_dram = addr < DRAM_LIMIT; // R16

    // ---------------------------------------------------------------
    // reset sequencer
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] rst_cnt_q;
    logic [CNT_W-1:0] rst_cnt_d;
    logic             rst_act_q;
    logic             rst_act_d;

    always_comb begin
        rst_cnt_d = rst_cnt_q;
        rst_act_d = rst_act_q;
        if (!reset_in_n) begin
            rst_cnt_d = CNT_W'(RST_CYCLES); // R9
            rst_act_d = 1'b1;
        end else if (rst_act_q) begin
            if (rst_cnt_q <= 16'h0001) begin
                rst_act_d = 1'b0;
            end else begin
                rst_cnt_d = rst_cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_cnt_q <= CNT_W'(RST_CYCLES);
            rst_act_q <= 1'b1;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            rst_act_q <= rst_act_d;
        end
    end

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    sbg_cnt_if wd ();
    logic strobe_q;

    assign wd.restart = strobe && !strobe_q; // R18
    assign wd.run     = strobe; // R18
    assign wd.limit   = CNT_W'(WDOG_CYCLES); // R17

    sbg_timer u_wdog (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ctl     (wd)
    );

    // ---------------------------------------------------------------
    // bus cycle control
    // ---------------------------------------------------------------
    sbg_bus_state_t st_q;
    sbg_bus_state_t st_d;
    logic [15:0]    dout_q;
    logic [15:0]    dout_d;
    logic [15:0]    doe_q;
    logic [15:0]    doe_d;
    logic [15:0]    wdat_q;
    logic [15:0]    wdat_d;
    logic [1:0]     wlan_q;
    logic [1:0]     wlan_d;
    logic           wstb_q;
    logic           wstb_d;
    logic           ack_q;
    logic           ack_d;
    logic           berr_q;
    logic           berr_d;
    logic           rom_n_q;
    logic           rom_n_d;
    logic           io_n_q;
    logic           io_n_d;
    logic           dram_q;
    logic           dram_d;

    always_comb begin
        st_d   = st_q;
        dout_d = dout_q;
        doe_d  = 16'h0000;
        wdat_d = wdat_q;
        wlan_d = wlan_q;
        wstb_d = 1'b0;
        ack_d  = 1'b0;
        berr_d = 1'b0;
        rom_n_d = !(sel && read_not_write && in_rom); // R11 R4
        io_n_d  = !(sel && in_io); // R12
        dram_d = sel && in_dram && !in_io;
        case (st_q)
            SBG_IDLE: begin
                if (sel && !rst_act_q) begin
                    if (!read_not_write) begin
                        wdat_d = data_in; // R2 R4
                        wlan_d = lanes;
                        wstb_d = 1'b1;
                    end
                    st_d = SBG_ACK;
                end
            end
            SBG_ACK: begin
                ack_d = 1'b1; // R6
                if (read_not_write) begin
                    dout_d = rd_data;
                    doe_d  = {{8{lanes[1]}}, {8{lanes[0]}}}; // R2 R3
                end
                if (!strobe) begin
                    st_d = SBG_IDLE;
                end else if (wd.expired) begin
                    st_d = SBG_BERR;
                end
            end
            SBG_BERR: begin
                berr_d = 1'b1; // R10
                if (!strobe) begin
                    st_d = SBG_IDLE;
                end
            end
            SBG_WAIT: begin
                st_d = SBG_IDLE;
            end
            default: begin
                st_d = SBG_IDLE;
            end
        endcase
        // unclaimed strobe still trips the watchdog; stale expiry ignored on restart
        if (st_q == SBG_IDLE && strobe && wd.expired && !wd.restart) begin
            st_d = SBG_BERR; // R10
        end
        if (!strobe && st_q != SBG_IDLE) begin
            doe_d = 16'h0000;
            ack_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q     <= SBG_IDLE;
            dout_q   <= DATA_RESET;
            doe_q    <= 16'h0000;
            wdat_q   <= DATA_RESET;
            wlan_q   <= 2'b00;
            wstb_q   <= 1'b0;
            ack_q    <= 1'b0;
            berr_q   <= 1'b0;
            rom_n_q  <= 1'b1;
            io_n_q   <= 1'b1;
            dram_q   <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            st_q     <= st_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
            wdat_q   <= wdat_d;
            wlan_q   <= wlan_d;
            wstb_q   <= wstb_d;
            ack_q    <= ack_d;
            berr_q   <= berr_d;
            rom_n_q  <= rom_n_d;
            io_n_q   <= io_n_d;
            dram_q   <= dram_d;
            strobe_q <= strobe;
        end
    end

    // ---------------------------------------------------------------
    // interrupt and clock dividers
    // ---------------------------------------------------------------
    logic       irq_q;
    logic       irq_d;
    logic [1:0] div_q;
    logic [1:0] div_d;

    always_comb begin
        irq_d = irq_req; // R13
        div_d = div_q + 2'b01; // R14 R15
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            div_q <= 2'b00;
        end else begin
            irq_q <= irq_d;
            div_q <= div_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs (open-drain pins: level low, enable high when pulling)
    // ---------------------------------------------------------------
    assign data_out              = dout_q;
    assign data_oe               = doe_q;
    assign wr_data               = wdat_q;
    assign wr_lanes              = wlan_q;
    assign wr_strobe             = wstb_q;
    assign dram_select           = dram_q;
    assign transfer_ack_n        = 1'b0;
    assign transfer_ack_oe       = ack_q; // R6
    assign reset_out_n           = 1'b0;
    assign reset_out_oe          = rst_act_q; // R7
    assign halt_out_n            = 1'b0;
    assign halt_out_oe           = rst_act_q; // R8
    assign bus_error_n           = 1'b0;
    assign bus_error_oe          = berr_q; // R10
    assign rom_select_n          = rom_n_q; // R11
    assign io_select_n           = io_n_q; // R12
    assign irq_out_n             = 1'b0;
    assign irq_out_oe            = irq_q; // R13
    assign crystal_half_clock    = div_q[0]; // R14
    assign crystal_quarter_clock = div_q[1]; // R15
endmodule
`default_nettype wire

// *** test/sbg_glue_properties.sv ***
// checker: concurrent properties on the glue top ports
`timescale 1ns/1ns
`default_nettype none
module sbg_glue_properties (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [20:1] addr,
    input wire logic        upper_byte_strobe_n,
    input wire logic        lower_byte_strobe_n,
    input wire logic        read_not_write,
    input wire logic        device_select_n,
    input wire logic        irq_req,
    input wire logic [15:0] data_oe,
    input wire logic        transfer_ack_oe,
    input wire logic        reset_out_oe,
    input wire logic        halt_out_oe,
    input wire logic        bus_error_oe,
    input wire logic        rom_select_n,
    input wire logic        io_select_n,
    input wire logic        irq_out_oe,
    input wire logic        crystal_half_clock,
    input wire logic        crystal_quarter_clock
);
    logic strb;
    logic sel;
    logic rom_hit;
    logic io_hit;
    assign strb    = !upper_byte_strobe_n || !lower_byte_strobe_n;
    assign sel     = strb && !device_select_n;
    assign rom_hit = sel && read_not_write && addr[20:19] == 2'b11;
    assign io_hit  = sel && addr[20:17] == 4'hb;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence seq_idle2;
        !strb [*2];
    endsequence
    sequence seq_q_hi_lo;
        crystal_quarter_clock ##1 !crystal_quarter_clock;
    endsequence
    a_reset_halt_pair: assert property (reset_out_oe == halt_out_oe)
        else $error("halt and reset outputs differ");
    a_ack_needs_cs: assert property ($rose(transfer_ack_oe) |-> $past(sel, 2))
        else $error("acknowledge without a selected strobe");
    a_ack_release: assert property (seq_idle2 |=> !transfer_ack_oe && data_oe == 16'h0000)
        else $error("acknowledge or data drive kept after strobes");
    a_rom_read_only: assert property (!rom_select_n |-> $past(rom_hit))
        else $error("rom select without strobed rom read");
    a_io_area_only: assert property (!io_select_n |-> $past(io_hit))
        else $error("io select without strobed io access");
    a_berr_release: assert property (seq_idle2 |=> !bus_error_oe)
        else $error("bus error kept after strobes");
    a_read_drive: assert property (|data_oe |-> $past(read_not_write))
        else $error("data driven on a write");
    a_half_toggle: assert property ($past(rst_n) |-> crystal_half_clock != $past(crystal_half_clock))
        else $error("half clock missed a toggle");
    a_quarter_step: assert property ($rose(crystal_quarter_clock) |=> seq_q_hi_lo)
        else $error("quarter clock wrong period");
    a_irq_mirror: assert property ($past(rst_n) |-> irq_out_oe == $past(irq_req))
        else $error("interrupt pin not following request");
endmodule
bind sbg_glue sbg_glue_properties sbg_glue_properties_inst (
    .clk_sys, .rst_n, .addr, .upper_byte_strobe_n, .lower_byte_strobe_n, .read_not_write,
    .device_select_n, .irq_req, .data_oe, .transfer_ack_oe, .reset_out_oe, .halt_out_oe,
    .bus_error_oe, .rom_select_n, .io_select_n, .irq_out_oe, .crystal_half_clock,
    .crystal_quarter_clock
);
`default_nettype wire

// *** test/sbg_cpu_model.sv ***
// model: bus master cpu on the glue system bus
`timescale 1ns/1ns
`default_nettype none
module sbg_cpu_model (
    input  wire logic        clk_sys,
    output logic      [20:1] addr,
    output logic      [15:0] data_in,
    input  wire logic [15:0] data_out,
    output logic             upper_byte_strobe_n,
    output logic             lower_byte_strobe_n,
    output logic             read_not_write,
    output logic             device_select_n,
    input  wire logic        ack_pin_n,
    input  wire logic        berr_pin_n
);
    initial begin
        addr                = 20'h00000;
        data_in             = 16'h0000;
        upper_byte_strobe_n = 1'b1;
        lower_byte_strobe_n = 1'b1;
        read_not_write      = 1'b1;
        device_select_n     = 1'b1;
    end
    // hold extra cycles after the acknowledge to act as a slow master
    task automatic cyc(input logic rnw, cs, input logic [20:1] a, input logic [1:0] ln,
                       input logic [15:0] wd, input int hold,
                       output logic [15:0] rd, output logic ok, be);
        ok = 1'b0;
        be = 1'b0;
        rd = 16'h0000;
        repeat (2) @(negedge clk_sys);
        addr            <= a;
        read_not_write  <= rnw;
        device_select_n <= !cs;
        data_in         <= rnw ? ~data_in : wd;
        @(negedge clk_sys);
        upper_byte_strobe_n <= !ln[0];
        lower_byte_strobe_n <= !ln[1];
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge clk_sys);
            ok = !ack_pin_n;
            rd = data_out;
        end
        repeat (hold) begin
            @(posedge clk_sys);
            be = be | !berr_pin_n;
        end
        @(negedge clk_sys);
        upper_byte_strobe_n <= 1'b1;
        lower_byte_strobe_n <= 1'b1;
        device_select_n     <= 1'b1;
        addr                <= ~addr;
        data_in             <= ~data_in;
    endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// testbench: directed scenarios for the system bus glue controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_n, reset_in_n, irq_req, ok, be;
    logic [20:1] addr;
    logic [15:0] data_in, data_out, data_oe, rd_data, wr_data, rd, ws_data;
    logic [1:0]  wr_lanes, ws_lanes;
    logic        upper_byte_strobe_n, lower_byte_strobe_n, read_not_write, device_select_n;
    logic        wr_strobe, dram_select, transfer_ack_oe, reset_out_oe, halt_out_oe;
    logic        bus_error_oe, rom_select_n, io_select_n, irq_out_oe;
    logic        crystal_half_clock, crystal_quarter_clock;
    logic [4:0]  od_lvl;
    logic [15:0] oe_seen;
    logic        rom_seen, io_seen, dram_seen, ws_seen;
    int          n_errors = 0;
    int          num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    sbg_glue #(.WDOG_CYCLES(20), .RST_CYCLES(8)) sbg_glue_inst (
        .clk_sys, .rst_n, .addr, .data_in, .data_out, .data_oe, .upper_byte_strobe_n,
        .lower_byte_strobe_n, .read_not_write, .device_select_n, .reset_in_n, .irq_req,
        .rd_data, .wr_data, .wr_lanes, .wr_strobe, .dram_select, .transfer_ack_n(od_lvl[0]),
        .transfer_ack_oe, .reset_out_n(od_lvl[1]), .reset_out_oe, .halt_out_n(od_lvl[2]),
        .halt_out_oe, .bus_error_n(od_lvl[3]), .bus_error_oe, .rom_select_n, .io_select_n,
        .irq_out_n(od_lvl[4]), .irq_out_oe, .crystal_half_clock, .crystal_quarter_clock
    );
    sbg_cpu_model sbg_cpu_model_inst (
        .clk_sys, .addr, .data_in, .data_out, .upper_byte_strobe_n, .lower_byte_strobe_n,
        .read_not_write, .device_select_n, .ack_pin_n(!transfer_ack_oe),
        .berr_pin_n(!bus_error_oe)
    );

    // sticky flags for outputs that stand only inside a cycle
    always @(posedge clk_sys) begin
        if (rom_select_n === 1'b0) rom_seen <= 1'b1;
        if (io_select_n === 1'b0) io_seen <= 1'b1;
        if (dram_select === 1'b1) dram_seen <= 1'b1;
        if (data_oe !== 16'h0000) oe_seen <= data_oe;
        if (wr_strobe === 1'b1) begin
            ws_seen  <= 1'b1;
            ws_data  <= wr_data;
            ws_lanes <= wr_lanes;
        end
    end

    task automatic check(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic bus(input logic rnw, cs, input logic [20:1] a, input logic [1:0] ln,
                       input logic [15:0] wd, input int hold);
        @(negedge clk_sys);
        {rom_seen, io_seen, dram_seen, ws_seen} = 4'h0;
        oe_seen = 16'h0000;
        sbg_cpu_model_inst.cyc(rnw, cs, a, ln, wd, hold, rd, ok, be);
    endtask

    task automatic t_seq;
        int n;
        n = 0;
        check("reset_out", reset_out_oe, 1'b1);
        check("halt_out", halt_out_oe, 1'b1);
        while (reset_out_oe === 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        check("seq_len", 16'(n >= 7 && n <= 12), 16'h0001);
        if (n >= 40) test_done;
    endtask

    task automatic t_reset_in;
        reset_in_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("seq_busy", reset_out_oe, 1'b1);
        reset_in_n = 1'b1;
        t_seq;
    endtask

    // entry: {read, dram, io, rom} expected per address
    task automatic t_map;
        logic [20:1] ta [8] = '{20'hc0010, 20'hc0010, 20'hb1234, 20'hb1234,
                                20'hbffff, 20'h00100, 20'haffff, 20'hc0000};
        logic [3:0]  te [8] = '{4'h9, 4'h0, 4'ha, 4'h2, 4'ha, 4'h4, 4'hc, 4'h9};
        logic [1:0]  ln;
        for (int i = 0; i < 8; i++) begin
            ln = 2'(i % 3 + 1);
            irq_req = ta[i][1];
            bus(te[i][3], 1'b1, ta[i], ln, 16'h3c5a, 0);
            check("ack", ok, 1'b1);
            if (ok !== 1'b1) test_done;
            check("dram_sel", dram_seen, te[i][2]);
            check("io_sel", io_seen, te[i][1]);
            check("rom_sel", rom_seen, te[i][0]);
            check("wr_strobe", ws_seen, !te[i][3]);
            if (te[i][3]) check("rd_data", rd, rd_data);
            check("data_oe", oe_seen, te[i][3] ? {{8{ln[1]}}, {8{ln[0]}}} : 16'h0000);
            if (!te[i][3]) check("wr_lanes", ws_lanes, ln);
            if (!te[i][3]) check("wr_data", ws_data, 16'h3c5a);
        end
    endtask

    task automatic t_no_cs;
        bus(1'b0, 1'b0, 20'hb1234, 2'b11, 16'hffff, 0);
        check("ack_nocs", ok, 1'b0);
        check("io_nocs", io_seen, 1'b0);
        check("wr_nocs", ws_seen, 1'b0);
    endtask

    // interrupt pin, open-drain levels and divided clocks
    task automatic t_pins;
        int   nh;
        int   nq;
        logic ph;
        logic pq;
        nh = 0;
        nq = 0;
        irq_req = 1'b1;
        @(negedge clk_sys);
        check("irq_on", irq_out_oe, 1'b1);
        irq_req = 1'b0;
        @(negedge clk_sys);
        check("irq_off", irq_out_oe, 1'b0);
        check("od_levels", {11'h000, od_lvl}, 16'h0000);
        ph = crystal_half_clock;
        pq = crystal_quarter_clock;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            nh += int'(crystal_half_clock !== ph);
            nq += int'(crystal_quarter_clock !== pq);
            ph = crystal_half_clock;
            pq = crystal_quarter_clock;
        end
        check("half_edges", 16'(nh), 16'h0008);
        check("quarter_edges", 16'(nq), 16'h0004);
    endtask

    task automatic t_wdog;
        bus(1'b1, 1'b1, 20'h00200, 2'b11, 16'h0000, 30);
        check("berr_late", be, 1'b1);
        bus(1'b1, 1'b1, 20'h00200, 2'b11, 16'h0000, 12);
        check("berr_short", be, 1'b0);
        check("ack_after", ok, 1'b1);
    endtask

    initial begin
        rst_n      = 1'b0;
        reset_in_n = 1'b1;
        irq_req    = 1'b0;
        rd_data    = 16'h5aa5;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        t_seq;
        t_map;
        t_no_cs;
        t_wdog;
        t_reset_in;
        t_map;
        t_pins;
        test_done;
    end
endmodule
`default_nettype wire
